// *** rtl/nchca_pkg.sv ***
// nchca_pkg: constants for the host command/status register block.
// assumes one 10 MHz host clock; shared by the top and the virtual engine.
package nchca_pkg;
    // register indices; register n sits at base + 4*n bytes
    localparam logic [31:0] CSR_BASE   = 32'h2000_8000;
    localparam logic [3:0]  CSR_VPB    = 4'h0;
    localparam logic [3:0]  CSR_TPD    = 4'h1;
    localparam logic [3:0]  CSR_RPD    = 4'h2;
    localparam logic [3:0]  CSR_STAT   = 4'h5;
    localparam logic [3:0]  CSR_CMD    = 4'h6;
    localparam logic [3:0]  CSR_VLO    = 4'h8;
    localparam logic [3:0]  CSR_VHI    = 4'he;
    localparam int          NUM_CSR    = 16;
    // vector/priority/bus-mode fields
    localparam int          PRIO_LO    = 30;
    localparam int          SYNC_BIT   = 29;
    localparam logic [31:0] VPB_RESET  = 32'h1fff_0003;
    localparam logic [12:0] VPB_ONES   = 13'h1fff;
    localparam logic [2:0]  LVL_TOP    = 3'h5;
    // status fields
    localparam int          MERR_BIT   = 4;
    localparam int          RU_BIT     = 3;
    localparam logic [7:0]  STAT_ONES  = 8'hff;
    // command register bits
    localparam int          CMD_RXGO   = 0;
    localparam int          CMD_TXGO   = 1;
    localparam int          CMD_RXSTOP = 2;
    localparam int          CMD_TXSTOP = 3;
    // process state codes as reported in status
    localparam logic [1:0]  PS_STOP    = 2'h0;
    localparam logic [1:0]  PS_RUN     = 2'h1;
    localparam logic [1:0]  PS_SUSP    = 2'h2;
    // timing
    localparam int          CLK_NS     = 100;
    localparam int          VIRT_NS    = 20000;
    localparam int          VIRT_CYC   = VIRT_NS / CLK_NS;
    localparam int          INIT_NS    = 25000000;
    localparam int          INIT_CYC   = INIT_NS / CLK_NS;
    typedef enum logic [2:0] {
        P_STOP = 3'b001,
        P_RUN  = 3'b010,
        P_SUSP = 3'b100
    } nchca_proc_e;
endpackage

// *** rtl/nchca_virt.sv ***
// nchca_virt: engine that serves the seven virtual registers.
// assumes the top starts it only while done is high.
`timescale 1ns/100ps
module nchca_virt (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    // request from the top
    input  wire logic        i_start,
    input  wire logic        i_wr,
    input  wire logic [2:0]  i_idx,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_take,
    // completion and result
    output logic             o_done,
    output logic             o_rvalid,
    output logic [2:0]       o_ridx,
    output logic [31:0]      o_rdata
);
    import nchca_pkg::*;

    typedef struct packed {
        logic             busy;
        logic [7:0]       cnt;
        logic             wr;
        logic [2:0]       idx;
        logic [31:0]      wdata;
        logic [6:0][31:0] mem;
        logic             rvalid;
        logic [31:0]      rdata;
    } nchca_virt_s;

    nchca_virt_s q;
    nchca_virt_s next_q;

    ////////////////////////////////////////////////////////////////
    // one action at a time; a slow service stands in for the processor
    always_comb begin
        next_q = q;
        if (i_take) begin
            next_q.rvalid = 1'b0;
        end
        if (i_start && !q.busy) begin
            next_q.busy   = 1'b1;
            next_q.cnt    = 8'(VIRT_CYC - 1);
            next_q.wr     = i_wr;
            next_q.idx    = i_idx;
            next_q.wdata  = i_wdata;
            next_q.rvalid = 1'b0;
        end else if (q.busy) begin
            next_q.cnt = q.cnt - 8'h1;
            if (q.cnt == 8'h0) begin
                next_q.busy = 1'b0;
                if (q.wr) begin
                    next_q.mem[q.idx] = q.wdata;
                end else begin
                    next_q.rdata  = q.mem[q.idx];
                    next_q.rvalid = 1'b1;
                end
            end
        end
    end

    // register the copy; idle, done and empty storage after reset
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_done   = !q.busy;
    assign o_rvalid = q.rvalid;
    assign o_ridx   = q.idx;
    assign o_rdata  = q.rdata;
endmodule

// *** rtl/nchca_top.sv ***
// nchca_top: host command/status registers of the network controller.
// assumes host bus and event inputs are on i_mclk; one access per strobe.
//
// Summary of operation
// - transmit and receive are independent three-state processes
// - writes and events move states; some need a state
// - suspended receive resumes on next recognised frame
// - sixteen host registers
// - register n at base plus four n; longword only
// - bits follow six access kinds
// - 0-7 and 15 physical, 8-14 virtual
// - physical access completes in one transaction
// - virtual access served slowly, up to 20 us
// - done flag low until virtual action finishes
// - virtual write completes at once, data taken later
// - first virtual read invalid, repeat read valid
// - parity error on write can raise interrupt
// - priority field picks interrupt level 14 to 17
// - bit 29 selects synchronous or asynchronous master
// - acknowledge drives vector, other bits zero
// - vector bits 1:0 read as one
// - poll demand write checks transmit list only while suspended
// - poll demand resumes suspended transmit
// - after initialisation both processes stopped
// - write parity error sets memory error flag
`timescale 1ns/100ps
module nchca_top #(
    parameter int INIT_CYCLES = nchca_pkg::INIT_CYC
) (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    // host register port
    input  wire logic        i_csr_sel,
    input  wire logic        i_csr_wr,
    input  wire logic [3:0]  i_csr_idx,
    input  wire logic [31:0] i_csr_wdata,
    input  wire logic        i_csr_wpar,
    output logic [31:0]      o_csr_rdata,
    output logic             o_csr_ack,
    // interrupt
    input  wire logic        i_iack,
    output logic             o_irq_req,
    output logic [4:0]       o_irq_level,
    output logic [31:0]      o_hda_out,
    output logic             o_hda_oe,
    output logic             o_sync_mode,
    // process events from the datapath
    input  wire logic        i_tx_list_empty,
    input  wire logic        i_rx_no_desc,
    input  wire logic        i_rx_frame_ok,
    input  wire logic        i_mem_err,
    output logic             o_tx_poll,
    output logic             o_rx_poll
);
    import nchca_pkg::*;

    typedef struct packed {
        logic             init_done;
        logic [31:0]      init_cnt;
        logic [1:0]       prio;
        logic             sync_sel;
        logic [13:0]      vec;
        nchca_proc_e      tx;
        nchca_proc_e      rx;
        logic             merr;
        logic             ru;
        logic [3:0][31:0] gp;
        logic [31:0]      rdata;
        logic             ack;
        logic [31:0]      hda;
        logic             hda_oe;
        logic             tx_poll;
        logic             rx_poll;
    } nchca_top_s;

    nchca_top_s q;
    nchca_top_s next_q;

    logic        perr;
    logic        wr_ok;
    logic        cmd_ok;
    logic        virt;
    logic        v_done;
    logic        v_rvalid;
    logic [2:0]  v_ridx;
    logic [31:0] v_rdata;
    logic        v_hit;
    logic        v_start;
    logic        merr_set;
    logic        tx_poll_wr;
    logic        rx_poll_wr;
    logic [1:0]  ts;
    logic [1:0]  rs;
    logic [31:0] stat;

    ////////////////////////////////////////////////////////////////
    // decode; odd parity over the write word
    always_comb begin
        perr       = i_csr_sel && i_csr_wr && !(^{i_csr_wdata, i_csr_wpar});
        wr_ok      = i_csr_sel && i_csr_wr && !perr;
        cmd_ok     = wr_ok && q.init_done; // commands ignored during init
        virt       = i_csr_idx >= CSR_VLO && i_csr_idx <= CSR_VHI;
        v_hit      = i_csr_sel && virt && !i_csr_wr && v_rvalid
                     && (v_ridx == 3'(i_csr_idx - CSR_VLO));
        v_start    = i_csr_sel && virt && !perr && !v_hit && v_done;
        merr_set   = perr || i_mem_err;
        tx_poll_wr = cmd_ok && i_csr_idx == CSR_TPD;
        rx_poll_wr = cmd_ok && i_csr_idx == CSR_RPD;
    end

    // state code for the status word
    function automatic logic [1:0] enc(input nchca_proc_e s);
        case (s)
            P_RUN:   enc = PS_RUN;
            P_SUSP:  enc = PS_SUSP;
            default: enc = PS_STOP;
        endcase
    endfunction

    always_comb begin
        ts   = enc(q.tx);
        rs   = enc(q.rx);
        stat = {q.init_done, 1'b0, 4'h0, ts, rs, 5'h00, v_done,
                STAT_ONES, 3'h0, q.merr, q.ru, 3'h0};
    end

    ////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        next_q         = q;
        next_q.ack     = i_csr_sel;
        next_q.hda_oe  = i_iack;
        next_q.hda     = i_iack ? {16'h0, q.vec, 2'b00} : 32'h0;
        next_q.tx_poll = 1'b0;
        next_q.rx_poll = 1'b0;
        // initialisation count
        if (!q.init_done) begin
            next_q.init_cnt = q.init_cnt - 32'h1;
            if (q.init_cnt == 32'h0) begin
                next_q.init_done = 1'b1;
            end
        end
        // physical writes
        if (wr_ok) begin
            case (i_csr_idx)
                CSR_VPB: begin
                    next_q.prio     = i_csr_wdata[PRIO_LO +: 2];
                    next_q.sync_sel = i_csr_wdata[SYNC_BIT];
                    next_q.vec      = i_csr_wdata[15:2];
                end
                CSR_STAT: begin
                    if (i_csr_wdata[MERR_BIT]) begin
                        next_q.merr = 1'b0;
                    end
                    if (i_csr_wdata[RU_BIT]) begin
                        next_q.ru = 1'b0;
                    end
                end
                4'h3: next_q.gp[0] = i_csr_wdata;
                4'h4: next_q.gp[1] = i_csr_wdata;
                4'h7: next_q.gp[2] = i_csr_wdata;
                4'hf: next_q.gp[3] = i_csr_wdata;
                default: ;
            endcase
        end
        // transmit process
        case (q.tx)
            P_STOP: begin
                if (cmd_ok && i_csr_idx == CSR_CMD && i_csr_wdata[CMD_TXGO]) begin
                    next_q.tx = P_RUN;
                end
            end
            P_RUN: begin
                if (cmd_ok && i_csr_idx == CSR_CMD && i_csr_wdata[CMD_TXSTOP]) begin
                    next_q.tx = P_STOP;
                end else if (i_tx_list_empty) begin
                    next_q.tx = P_SUSP;
                end
            end
            P_SUSP: begin
                if (cmd_ok && i_csr_idx == CSR_CMD && i_csr_wdata[CMD_TXSTOP]) begin
                    next_q.tx = P_STOP;
                end else if (tx_poll_wr) begin
                    next_q.tx = P_RUN;
                end
            end
            default: next_q.tx = P_STOP;
        endcase
        // poll demand kicks the list scan only in suspend; bit 0 value is meaningless
        next_q.tx_poll = tx_poll_wr && q.tx == P_SUSP;
        // receive process
        case (q.rx)
            P_STOP: begin
                if (cmd_ok && i_csr_idx == CSR_CMD && i_csr_wdata[CMD_RXGO]) begin
                    next_q.rx = P_RUN;
                end
            end
            P_RUN: begin
                if (cmd_ok && i_csr_idx == CSR_CMD && i_csr_wdata[CMD_RXSTOP]) begin
                    next_q.rx = P_STOP;
                end else if (i_rx_no_desc) begin
                    next_q.rx = P_SUSP;
                    next_q.ru = 1'b1; // set beats clear
                end
            end
            P_SUSP: begin
                if (cmd_ok && i_csr_idx == CSR_CMD && i_csr_wdata[CMD_RXSTOP]) begin
                    next_q.rx = P_STOP;
                end else if (rx_poll_wr || i_rx_frame_ok) begin
                    next_q.rx = P_RUN;
                end
            end
            default: next_q.rx = P_STOP;
        endcase
        next_q.rx_poll = rx_poll_wr && q.rx == P_SUSP;
        // memory error aborts both processes; set wins over clear
        if (merr_set) begin
            next_q.merr = 1'b1;
            next_q.tx = P_STOP;
            next_q.rx = P_STOP;
        end
        if (!q.init_done) begin
            next_q.tx = P_STOP;
            next_q.rx = P_STOP;
        end
        // read data, answered in the same transaction
        next_q.rdata = 32'h0;
        if (i_csr_sel && !i_csr_wr) begin
            case (i_csr_idx)
                CSR_VPB:  next_q.rdata = {q.prio, q.sync_sel, VPB_ONES, q.vec, 2'b11};
                CSR_TPD:  next_q.rdata = '1; // write-only, reads as ones
                CSR_RPD:  next_q.rdata = '1;
                CSR_STAT: next_q.rdata = stat;
                4'h3:     next_q.rdata = q.gp[0];
                4'h4:     next_q.rdata = q.gp[1];
                4'h7:     next_q.rdata = q.gp[2];
                4'hf:     next_q.rdata = q.gp[3];
                default:  next_q.rdata = v_hit ? v_rdata : 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            q          <= '0;
            q.init_cnt <= 32'(INIT_CYCLES - 1);
            q.prio     <= VPB_RESET[PRIO_LO +: 2];
            q.sync_sel <= VPB_RESET[SYNC_BIT];
            q.vec      <= VPB_RESET[15:2];
            q.tx       <= P_STOP;
            q.rx       <= P_STOP;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // virtual register engine; slow so the host bus is never held
    nchca_virt u_virt (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_start  (v_start),
        .i_wr     (i_csr_wr),
        .i_idx    (3'(i_csr_idx - CSR_VLO)),
        .i_wdata  (i_csr_wdata),
        .i_take   (v_hit),
        .o_done   (v_done),
        .o_rvalid (v_rvalid),
        .o_ridx   (v_ridx),
        .o_rdata  (v_rdata)
    );

    // outputs straight from flops
    assign o_csr_rdata = q.rdata;
    assign o_csr_ack   = q.ack;
    assign o_irq_req   = q.merr;
    assign o_irq_level = {LVL_TOP, q.prio};
    assign o_hda_out   = q.hda;
    assign o_hda_oe    = q.hda_oe;
    assign o_sync_mode = q.sync_sel;
    assign o_tx_poll   = q.tx_poll;
    assign o_rx_poll   = q.rx_poll;

    ////////////////////////////////////////////////////////////////
    // checks
    localparam int VMAX = 201;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    chk_ack_next: assert property (i_csr_sel |=> o_csr_ack)
        else $error("no ack one cycle after access");
    chk_done_drop: assert property (v_start |=> !v_done)
        else $error("done still high after virtual start");
    chk_done_back: assert property (v_start |-> ##[1:VMAX] v_done)
        else $error("virtual access not done in time");
    chk_vec_ones: assert property (i_csr_sel && !i_csr_wr && i_csr_idx == CSR_VPB
        |=> o_csr_rdata[1:0] == 2'b11)
        else $error("vector low bits not one");
    chk_iack_drive: assert property (i_iack |=> o_hda_oe && o_hda_out[31:16] == 16'h0
        && o_hda_out[1:0] == 2'b00 && o_hda_out[15:2] == $past(q.vec))
        else $error("bad vector on acknowledge");
    chk_poll_resume: assert property (tx_poll_wr && q.tx == P_SUSP && !merr_set
        |=> q.tx == P_RUN && o_tx_poll)
        else $error("poll demand did not resume transmit");
    // a list-empty event or an abort in the same cycle may still move the state
    chk_poll_ignore: assert property (tx_poll_wr && q.tx != P_SUSP && !i_tx_list_empty
        && !merr_set |=> !o_tx_poll && q.tx == $past(q.tx))
        else $error("poll demand acted outside suspend");
    chk_parity_merr: assert property (perr |=> q.merr && q.tx == P_STOP && o_irq_req)
        else $error("parity error did not set memory error");
    chk_rx_frame: assert property (q.rx == P_SUSP && i_rx_frame_ok && !merr_set
        && !(cmd_ok && i_csr_idx == CSR_CMD) |=> q.rx == P_RUN)
        else $error("frame did not resume receive");
    chk_init_stop: assert property ($rose(q.init_done)
        |-> q.tx == P_STOP && q.rx == P_STOP)
        else $error("process running at end of init");

    cov_virt_read: cover property (v_start && !i_csr_wr ##[1:VMAX] v_hit);
    cov_tx_resume: cover property (q.tx == P_SUSP ##1 q.tx == P_RUN);
    cov_par_err: cover property (perr);
endmodule

// *** verification/nchca_host_model.sv ***
// nchca_host_model: host processor side of the register port.
// assumes the bench makes one call at a time on the 10 MHz clock.
`timescale 1ns/100ps
module nchca_host_model (
    // clock
    input  wire logic        i_mclk,
    // request towards the device
    output logic             o_csr_sel,
    output logic             o_csr_wr,
    output logic [3:0]       o_csr_idx,
    output logic [31:0]      o_csr_wdata,
    output logic             o_csr_wpar,
    // answer from the device
    input  wire logic [31:0] i_csr_rdata,
    input  wire logic        i_csr_ack
);
    import nchca_pkg::*;

    // idle port at time zero
    initial begin
        o_csr_sel   = 1'b0;
        o_csr_wr    = 1'b0;
        o_csr_idx   = 4'h0;
        o_csr_wdata = 32'h0;
        o_csr_wpar  = 1'b1;
    end

    ////////////////////////////////////////
    // one longword access; bad flips parity on purpose
    task automatic access(input logic wr, input logic [3:0] idx, input logic [31:0] d,
                          input logic bad, output logic [31:0] q, output logic ack);
        @(posedge i_mclk);
        o_csr_sel   <= 1'b1;
        o_csr_wr    <= wr;
        o_csr_idx   <= idx;
        o_csr_wdata <= d;
        o_csr_wpar  <= ~(^d) ^ bad;
        @(posedge i_mclk);
        o_csr_sel   <= 1'b0;
        o_csr_wdata <= ~d; // released data never repeats the word
        #1;
        q   = i_csr_rdata;
        ack = i_csr_ack;
    endtask

    // poll done before any further virtual access; bounded
    task automatic wait_done(output int polls);
        logic [31:0] q;
        logic        a;
        polls = 0;
        do begin
            access(1'b0, CSR_STAT, 32'h0, 1'b0, q, a);
            polls++;
        end while (q[16] !== 1'b1 && polls < 400);
    endtask
endmodule

// *** verification/nchca_tb_top.sv ***
// nchca_tb_top: self-checking bench for the host register block.
// assumes the host model owns the register port; events come from here.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module nchca_tb_top;
    import nchca_pkg::*;
    localparam int INIT_N = 60;   // short init, long enough to test early commands
    localparam int LIMIT  = 5000; // run needs about 600 cycles
    logic        i_mclk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_iack = 1'b0;
    logic [3:0]  ev     = 4'h0; // mem_err, frame_ok, no_desc, list_empty
    logic        sel, wr, wpar, ack, irq_req, hda_oe, sync_mode, tx_poll, rx_poll, a;
    logic [3:0]  idx;
    logic [4:0]  irq_level;
    logic [31:0] wdata, rdata, hda_out, q, v;
    logic [3:0]  pr [4] = '{4'h3, 4'h4, 4'h7, 4'hf};
    int          n_fail = 0, total_checks = 0, cyc = 0, tx_polls = 0, rx_polls = 0, polls, k;

    nchca_host_model host (.i_mclk(i_mclk), .o_csr_sel(sel), .o_csr_wr(wr),
        .o_csr_idx(idx), .o_csr_wdata(wdata), .o_csr_wpar(wpar),
        .i_csr_rdata(rdata), .i_csr_ack(ack));

    nchca_top #(.INIT_CYCLES(INIT_N)) uut (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_csr_sel(sel), .i_csr_wr(wr), .i_csr_idx(idx), .i_csr_wdata(wdata),
        .i_csr_wpar(wpar), .o_csr_rdata(rdata), .o_csr_ack(ack), .i_iack(i_iack),
        .o_irq_req(irq_req), .o_irq_level(irq_level), .o_hda_out(hda_out),
        .o_hda_oe(hda_oe), .o_sync_mode(sync_mode), .i_tx_list_empty(ev[0]),
        .i_rx_no_desc(ev[1]), .i_rx_frame_ok(ev[2]), .i_mem_err(ev[3]),
        .o_tx_poll(tx_poll), .o_rx_poll(rx_poll));

    // 10 MHz clock
    always #50 i_mclk = ~i_mclk;

    // cycle ceiling and poll pulse count
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (tx_poll === 1'b1) begin
            tx_polls <= tx_polls + 1;
        end
        if (rx_poll === 1'b1) begin
            rx_polls <= rx_polls + 1;
        end
        if (cyc == LIMIT) begin
            n_fail++;
            stop_test();
        end
    end

    ////////////////////////////////////////
    task automatic stop_test();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] i, input logic [31:0] d);
        host.access(1'b1, i, d, 1'b0, q, a);
        `CHK(a, 1'b1)
    endtask

    task automatic rd_reg(input logic [3:0] i, input logic [31:0] e);
        host.access(1'b0, i, 32'h0, 1'b0, q, a);
        `CHK(a, 1'b1)
        `CHK(q, e)
    endtask

    // status word from flags {init, done, me, ru} and process states
    function automatic logic [31:0] stw(input logic [3:0] f, input logic [1:0] ts, rs);
        return {f[3], 5'h0, ts, rs, 5'h0, f[2], STAT_ONES, 3'h0, f[1], f[0], 3'h0};
    endfunction

    task automatic st(input logic [3:0] f, input logic [1:0] ts, rs);
        rd_reg(CSR_STAT, stw(f, ts, rs));
    endtask

    task automatic pulse(input logic [3:0] m);
        @(posedge i_mclk);
        ev <= m;
        @(posedge i_mclk);
        ev <= 4'h0;
    endtask

    task automatic iack_chk(input logic [31:0] e);
        @(posedge i_mclk);
        i_iack <= 1'b1;
        @(posedge i_mclk);
        i_iack <= 1'b0;
        #1;
        `CHK(hda_oe, 1'b1)
        `CHK(hda_out, e)
        @(posedge i_mclk);
        #1;
        `CHK(hda_oe, 1'b0)
    endtask

    ////////////////////////////////////////
    // main sequence: reset, vector register first, then the rest
    initial begin
        repeat (3) @(posedge i_mclk);
        `CHK(irq_level, 5'h14)
        i_rstn <= 1'b1;
        rd_reg(CSR_VPB, VPB_RESET);
        // low vector bits written as 00, 01, 10 and 11 must all be ignored
        for (int p = 0; p < 4; p++) begin
            v = {2'(p), 1'(p), 13'h0, 16'h5a40 + 16'(p * 5)};
            wr_reg(CSR_VPB, v);
            rd_reg(CSR_VPB, {v[31:29], VPB_ONES, v[15:2], 2'b11});
            `CHK(irq_level, 5'h14 + 5'(p))
            `CHK(sync_mode, v[29])
            iack_chk({16'h0, v[15:2], 2'b00});
        end
        st(4'h4, PS_STOP, PS_STOP);
        wr_reg(CSR_CMD, 32'h3);
        st(4'h4, PS_STOP, PS_STOP);
        repeat (INIT_N) @(posedge i_mclk);
        st(4'hc, PS_STOP, PS_STOP);
        // map: distinct words at each plain register
        foreach (pr[j]) wr_reg(pr[j], {8{pr[j]}});
        foreach (pr[j]) rd_reg(pr[j], {8{pr[j]}});
        rd_reg(CSR_TPD, 32'hffff_ffff);
        rd_reg(CSR_CMD, 32'h0);
        // transmit process and poll demand
        k = tx_polls;
        wr_reg(CSR_TPD, 32'hffff_ffff);
        wr_reg(CSR_CMD, 32'h1 << CMD_TXGO);
        st(4'hc, PS_RUN, PS_STOP);
        wr_reg(CSR_TPD, 32'hffff_ffff);
        st(4'hc, PS_RUN, PS_STOP);
        `CHK(tx_polls, k)
        pulse(4'h1);
        st(4'hc, PS_SUSP, PS_STOP);
        wr_reg(CSR_TPD, 32'hffff_fffe);
        st(4'hc, PS_RUN, PS_STOP);
        `CHK(tx_polls, k + 1)
        // receive process: suspend on no descriptor, resume on a frame
        wr_reg(CSR_CMD, 32'h1 << CMD_RXGO);
        st(4'hc, PS_RUN, PS_RUN);
        pulse(4'h2);
        st(4'hd, PS_RUN, PS_SUSP);
        k = rx_polls;
        wr_reg(CSR_RPD, 32'hffff_ffff);
        st(4'hd, PS_RUN, PS_RUN);
        `CHK(rx_polls, k + 1)
        pulse(4'h2);
        st(4'hd, PS_RUN, PS_SUSP);
        pulse(4'h4);
        st(4'hd, PS_RUN, PS_RUN);
        wr_reg(CSR_STAT, 32'h0);
        st(4'hd, PS_RUN, PS_RUN);
        wr_reg(CSR_STAT, 32'h8);
        st(4'hc, PS_RUN, PS_RUN);
        // external memory error aborts both, then restart them
        pulse(4'h8);
        st(4'he, PS_STOP, PS_STOP);
        `CHK(irq_req, 1'b1)
        wr_reg(CSR_STAT, 32'h10);
        wr_reg(CSR_CMD, 32'h3);
        st(4'hc, PS_RUN, PS_RUN);
        // parity error stops both and raises the request
        host.access(1'b1, 4'h3, 32'h5555_aaaa, 1'b1, q, a);
        st(4'he, PS_STOP, PS_STOP);
        `CHK(irq_req, 1'b1)
        rd_reg(4'h3, 32'h3333_3333);
        wr_reg(CSR_STAT, 32'h10);
        st(4'hc, PS_STOP, PS_STOP);
        `CHK(irq_req, 1'b0)
        // virtual write then read twice
        wr_reg(CSR_VLO + 4'h1, 32'hc0de_1234);
        st(4'h8, PS_STOP, PS_STOP);
        host.wait_done(polls);
        `CHK(polls <= VIRT_CYC / 2 + 3, 1'b1)
        rd_reg(CSR_VLO + 4'h1, 32'h0);
        host.wait_done(polls);
        rd_reg(CSR_VLO + 4'h1, 32'hc0de_1234);
        stop_test();
    end
endmodule
